// >>> inc/smv_map.svh
`ifndef SMV_MAP_SVH
`define SMV_MAP_SVH

// Register regions, inclusive bounds
`define SMV_DIRECT_LO 16'h0000
`define SMV_DIRECT_HI 16'h005f
`define SMV_HIGH_LO 16'h1800
`define SMV_HIGH_HI 16'h184f
`define SMV_NVREG_LO 16'hffb0
`define SMV_NVREG_HI 16'hffbf

// Vector high-byte addresses, low byte follows at +1
`define SMV_VEC_RESET 16'hfffe
`define SMV_VEC_SWTRAP 16'hfffc
`define SMV_VEC_LOWSUP 16'hfffa
`define SMV_VEC_EXTREQ 16'hfff8
`define SMV_VEC_T1CH0 16'hfff4
`define SMV_VEC_T1CH1 16'hfff2
`define SMV_VEC_T1OVF 16'hfff0
`define SMV_VEC_T2CH0 16'hffee
`define SMV_VEC_T2OVF 16'hffea
`define SMV_VEC_KEYPAD 16'hffda
`define SMV_VEC_CONV 16'hffd8
`define SMV_VEC_WAKE 16'hffd0

// Free vector space, ordinary program storage
`define SMV_FREE_LO 16'hffc0
`define SMV_FREE_HI 16'hffcf
// Reserved vector slots
`define SMV_RSV_LO 16'hffd2
`define SMV_RSV_HI 16'hfff7

`endif

// >>> inc/smv_pkg.sv
package smv_pkg;

    // Power state of one on-chip unit
    typedef enum logic [1:0] {
        SMV_PWR_ON,
        SMV_PWR_STANDBY,
        SMV_PWR_OFF
    } smv_pwr_type;

    // Operating mode of the device
    typedef enum logic [1:0] {
        SMV_RUN,
        SMV_STOP2,
        SMV_STOP3
    } smv_mode_type;

    // Interrupt sources, one-hot input vector positions
    typedef enum logic [3:0] {
        SMV_SRC_RESET,
        SMV_SRC_SWTRAP,
        SMV_SRC_LOWSUP,
        SMV_SRC_EXTREQ,
        SMV_SRC_T1CH0,
        SMV_SRC_T1CH1,
        SMV_SRC_T1OVF,
        SMV_SRC_T2CH0,
        SMV_SRC_T2OVF,
        SMV_SRC_KEYPAD,
        SMV_SRC_CONV,
        SMV_SRC_WAKE
    } smv_src_type;

    // Power state of every unit while stopped
    typedef struct packed {
        smv_pwr_type core;
        smv_pwr_type ram;
        smv_pwr_type flash;
        smv_pwr_type ports;
        smv_pwr_type converter;
        smv_pwr_type clock_gen;
        smv_pwr_type timers;
        smv_pwr_type regulator;
        smv_pwr_type wake_timer;
        logic pins_held;
    } smv_power_type;

    // Region hits of the address decoder
    typedef struct packed {
        logic direct;
        logic high;
        logic nvreg;
    } smv_region_type;

endpackage : smv_pkg

// >>> design/smv_stop_vector.sv
`timescale 1ns/1ps
`default_nettype none
`include "smv_map.svh"

// Function
// RULE1 - Detector raises interrupt or reset per configuration
// RULE2 - Detector on in stop keeps regulator active
// RULE3 - Stop2 request becomes stop3 when detector on
// RULE4 - Stop3 with detector: standby units, regulator active
// RULE5 - Stop mode halts all peripheral clocks
// RULE6 - Debug enable never keeps peripheral clocks running
// RULE7 - Stop2 powers off core, flash, ports, clocks
// RULE8 - Stop3 standby; converter on only with conditions
// RULE9 - Decode direct, high and nonvolatile register regions
// RULE10 - Fixed vector addresses, high byte first
// RULE11 - No source uses 0xffc0 to 0xffcf
// RULE12 - Never fetch reserved vector slots
module smv_stop_vector
    import smv_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic supply_low,
    input wire logic supply_detector_enable,
    input wire logic supply_detector_stop_enable,
    input wire logic supply_detector_reset_select,
    input wire logic partial_powerdown_select,
    input wire logic debug_mode_enable,
    input wire logic clock_gen_stop_enable,
    input wire logic converter_async_clock,
    input wire logic wake_timer_stop_enable,
    input wire logic stop_request,
    input wire logic wake_event,
    input wire logic [11:0] irq_pending,
    input wire logic vector_req,
    input wire logic [15:0] bus_addr,
    output logic supply_irq,
    output logic supply_reset,
    output smv_mode_type stop_mode,
    output logic periph_clk_en,
    output logic debug_clk_en,
    output smv_power_type power,
    output smv_region_type region,
    output logic vector_valid,
    output logic [15:0] vector_addr,
    output logic vector_hi_first
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (reset);

    // ************************************************************
    // Synchronisers for pin-level inputs
    // ************************************************************
    logic [1:0] low_sync_reg;
    logic supply_low_s;

    // Supply comparator is asynchronous to the bus clock
    always_ff @(posedge mclk) begin
        if (reset) begin
            low_sync_reg <= 2'h0;
        end else begin
            low_sync_reg <= {low_sync_reg[0], supply_low};
        end
    end
    assign supply_low_s = low_sync_reg[1];

    // ************************************************************
    // Low supply detector response
    // ************************************************************
    wire detect_active = supply_detector_enable & supply_low_s;
    logic supply_irq_reg;
    logic supply_reset_reg;

    // Reset or interrupt chosen by configuration, held while low
    always_ff @(posedge mclk) begin
        if (reset) begin
            supply_irq_reg <= 1'b0;
            supply_reset_reg <= 1'b0;
        end else begin
            supply_irq_reg <= detect_active & ~supply_detector_reset_select;
            supply_reset_reg <= detect_active & supply_detector_reset_select;
        end
    end
    assign supply_irq = supply_irq_reg; // RULE1
    assign supply_reset = supply_reset_reg; // RULE1

    // ************************************************************
    // Stop mode selection
    // ************************************************************
    wire det_in_stop = supply_detector_enable & supply_detector_stop_enable;
    // Debug also forbids the deep stop, since it needs the regulator
    wire deep_ok = partial_powerdown_select & ~det_in_stop
                   & ~debug_mode_enable; // RULE3
    smv_mode_type mode_reg;
    smv_mode_type mode_next;
    logic det_stop_reg;

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            SMV_RUN: begin
                if (stop_request) begin
                    mode_next = deep_ok ? SMV_STOP2 : SMV_STOP3; // RULE3
                end
            end
            SMV_STOP2, SMV_STOP3: begin
                if (wake_event) begin
                    mode_next = SMV_RUN;
                end
            end
            default: mode_next = SMV_RUN;
        endcase
    end

    // Detector setting latched on stop entry; it shapes the stop3 map
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_reg <= SMV_RUN;
            det_stop_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (mode_reg == SMV_RUN && stop_request) begin
                det_stop_reg <= det_in_stop;
            end
        end
    end
    assign stop_mode = mode_reg;

    // ************************************************************
    // Clock gating and power map
    // ************************************************************
    wire stopped = (mode_reg != SMV_RUN);
    // Peripherals stop regardless of debug, to save power
    assign periph_clk_en = ~stopped; // RULE5 RULE6
    assign debug_clk_en = ~stopped | debug_mode_enable;

    wire conv_on = converter_async_clock & det_stop_reg; // RULE8
    wire reg_active = det_stop_reg | debug_mode_enable; // RULE2

    always_comb begin
        power = '{SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON,
                  SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON,
                  SMV_PWR_ON, 1'b0};
        if (mode_reg == SMV_STOP2) begin
            power.core = SMV_PWR_OFF; // RULE7
            power.ram = SMV_PWR_STANDBY;
            power.flash = SMV_PWR_OFF;
            power.ports = SMV_PWR_OFF;
            power.converter = SMV_PWR_OFF;
            power.clock_gen = SMV_PWR_OFF;
            power.timers = SMV_PWR_OFF;
            power.regulator = SMV_PWR_STANDBY;
            power.wake_timer = wake_timer_stop_enable ? SMV_PWR_ON
                                                      : SMV_PWR_OFF;
            power.pins_held = 1'b1;
        end else if (mode_reg == SMV_STOP3) begin
            power.core = SMV_PWR_STANDBY; // RULE8 RULE4
            power.ram = SMV_PWR_STANDBY;
            power.flash = SMV_PWR_STANDBY;
            power.ports = SMV_PWR_STANDBY;
            power.converter = conv_on ? SMV_PWR_ON : SMV_PWR_STANDBY;
            power.timers = SMV_PWR_STANDBY;
            // Clock source runs only when asked to, or for debug
            power.clock_gen = (clock_gen_stop_enable | debug_mode_enable)
                ? SMV_PWR_ON : (det_stop_reg ? SMV_PWR_OFF
                                             : SMV_PWR_STANDBY); // RULE4
            power.regulator = reg_active ? SMV_PWR_ON
                                         : SMV_PWR_STANDBY; // RULE2
            power.wake_timer = wake_timer_stop_enable ? SMV_PWR_ON
                                                      : SMV_PWR_STANDBY;
            power.pins_held = 1'b1;
        end
    end

    // ************************************************************
    // Register region decoder
    // ************************************************************
    function automatic logic in_range(input logic [15:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    assign region.direct = in_range(bus_addr, `SMV_DIRECT_LO,
                                    `SMV_DIRECT_HI); // RULE9
    assign region.high = in_range(bus_addr, `SMV_HIGH_LO, `SMV_HIGH_HI);
    assign region.nvreg = in_range(bus_addr, `SMV_NVREG_LO,
                                   `SMV_NVREG_HI);

    // ************************************************************
    // Vector fetch
    // ************************************************************
    // Fixed priority: lowest index (reset) wins; the default branch gives the wake vector
    function automatic logic [15:0] vec_of(input logic [11:0] p);
        vec_of = 16'h0000;
        for (int i = 11; i >= 0; i--) begin
            if (p[i]) begin
                unique case (i)
                    0: vec_of = `SMV_VEC_RESET;
                    1: vec_of = `SMV_VEC_SWTRAP;
                    2: vec_of = `SMV_VEC_LOWSUP;
                    3: vec_of = `SMV_VEC_EXTREQ;
                    4: vec_of = `SMV_VEC_T1CH0;
                    5: vec_of = `SMV_VEC_T1CH1;
                    6: vec_of = `SMV_VEC_T1OVF;
                    7: vec_of = `SMV_VEC_T2CH0;
                    8: vec_of = `SMV_VEC_T2OVF;
                    9: vec_of = `SMV_VEC_KEYPAD;
                    10: vec_of = `SMV_VEC_CONV;
                    default: vec_of = `SMV_VEC_WAKE;
                endcase
            end
        end
    endfunction : vec_of

    logic vector_valid_reg;
    logic [15:0] vector_addr_reg;
    wire any_pending = |irq_pending;

    // Only table entries come out; free and reserved slots never do
    always_ff @(posedge mclk) begin
        if (reset) begin
            vector_valid_reg <= 1'b0;
            vector_addr_reg <= 16'h0000;
        end else begin
            vector_valid_reg <= vector_req & any_pending;
            if (vector_req & any_pending) begin
                vector_addr_reg <= vec_of(irq_pending); // RULE10 RULE11 RULE12
            end
        end
    end
    assign vector_valid = vector_valid_reg;
    assign vector_addr = vector_addr_reg;
    assign vector_hi_first = 1'b1; // RULE10

    // ************************************************************
    // Checks
    // ************************************************************
    a_lvd_resp_irq: assert property ( // RULE1
        ($past(detect_active) && !$past(supply_detector_reset_select))
        |-> supply_irq && !supply_reset)
        else $error("detector interrupt missing");

    a_reg_held_active: assert property ( // RULE2
        (mode_reg == SMV_STOP3 && det_stop_reg)
        |-> power.regulator == SMV_PWR_ON)
        else $error("regulator not active in stop");

    sequence s_stop_req_det;
        mode_reg == SMV_RUN && stop_request && det_in_stop;
    endsequence
    a_stop3_forced: assert property ( // RULE3
        s_stop_req_det |=> mode_reg == SMV_STOP3)
        else $error("stop2 entered with detector on");

    a_stop3_map: assert property ( // RULE4
        mode_reg == SMV_STOP3 |-> power.core == SMV_PWR_STANDBY
        && power.ram == SMV_PWR_STANDBY && power.pins_held)
        else $error("stop3 power map wrong");

    a_clk_halted: assert property ( // RULE5
        (mode_reg == SMV_RUN && stop_request) |=> !periph_clk_en)
        else $error("peripheral clock runs in stop");

    a_dbg_clk_gated: assert property ( // RULE6
        (stopped && debug_mode_enable) |-> !periph_clk_en && debug_clk_en)
        else $error("debug kept peripheral clock");

    a_stop2_off: assert property ( // RULE7
        mode_reg == SMV_STOP2 |-> power.core == SMV_PWR_OFF
        && power.flash == SMV_PWR_OFF && power.regulator == SMV_PWR_STANDBY)
        else $error("stop2 power map wrong");

    a_conv_gate: assert property ( // RULE8
        (mode_reg == SMV_STOP3 && !conv_on)
        |-> power.converter == SMV_PWR_STANDBY)
        else $error("converter on without conditions");

    a_region_dec: assert property ( // RULE9
        region.high |-> bus_addr[15:8] == 8'h18 && bus_addr[7:0] <= 8'h4f)
        else $error("high region decode wrong");

    a_reset_vec: assert property ( // RULE10
        (vector_req && irq_pending[0]) |=> vector_valid
        && vector_addr == 16'hfffe)
        else $error("reset vector wrong");

    a_no_free_vec: assert property ( // RULE11
        vector_valid |-> vector_addr[15:4] != 12'hffc && !vector_addr[0])
        else $error("free vector space fetched");

    a_no_rsv_vec: assert property ( // RULE12
        vector_valid |-> !(vector_addr inside {[16'hffd2:16'hffd7],
        [16'hffdc:16'hffe9], [16'hffec:16'hffed], [16'hfff6:16'hfff7]}))
        else $error("reserved vector fetched");

endmodule : smv_stop_vector
`default_nettype wire

// >>> bench/smv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Processor core seen from the block
// ********************************************
module smv_core_model (
    input wire logic mclk,
    output logic stop_request,
    output logic vector_req,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr
);
    initial begin
        stop_request = 1'b0;
        vector_req = 1'b0;
    end

    // Stop is a one-cycle pulse, held across exactly one sampling edge
    task automatic exec_stop();
        @(posedge mclk);
        #1 stop_request = 1'b1;
        @(posedge mclk);
        #1 stop_request = 1'b0;
    endtask : exec_stop

    // Vector fetch; valid only stands one cycle, so sample right after it
    task automatic fetch(output logic got, output logic [15:0] hi_a,
                         output logic [15:0] lo_a);
        @(posedge mclk);
        #1 vector_req = 1'b1;
        @(posedge mclk);
        #1 vector_req = 1'b0;
        got = vector_valid;
        hi_a = vector_addr;
        lo_a = vector_addr + 16'h0001;
    endtask : fetch
endmodule : smv_core_model
`default_nettype wire

// >>> bench/tb_stop_mode_and_vector_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stop_mode_and_vector_map
    import smv_pkg::*;
;
    logic mclk, reset, supply_low, supply_detector_enable;
    logic supply_detector_stop_enable, supply_detector_reset_select;
    logic partial_powerdown_select, debug_mode_enable, clock_gen_stop_enable;
    logic converter_async_clock, wake_timer_stop_enable, stop_request;
    logic wake_event, vector_req, supply_irq, supply_reset, periph_clk_en;
    logic debug_clk_en, vector_valid, vector_hi_first, got, det;
    logic [11:0] irq_pending;
    logic [15:0] bus_addr, vector_addr, ha, la, prev;
    logic [3:0] k;
    smv_mode_type stop_mode, m;
    smv_power_type power, pe;
    smv_region_type region;
    int err_count, comparisons, cycles, i, j;
    logic [15:0] vec_tab [12] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8,
        16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffea, 16'hffda,
        16'hffd8, 16'hffd0};
    logic [15:0] edges [11] = '{16'h0000, 16'h005f, 16'h0060, 16'h17ff,
        16'h1800, 16'h184f, 16'h1850, 16'hffaf, 16'hffb0, 16'hffbf, 16'hffc0};

    smv_stop_vector u_dut (.mclk(mclk), .reset(reset),
        .supply_low(supply_low),
        .supply_detector_enable(supply_detector_enable),
        .supply_detector_stop_enable(supply_detector_stop_enable),
        .supply_detector_reset_select(supply_detector_reset_select),
        .partial_powerdown_select(partial_powerdown_select),
        .debug_mode_enable(debug_mode_enable),
        .clock_gen_stop_enable(clock_gen_stop_enable),
        .converter_async_clock(converter_async_clock),
        .wake_timer_stop_enable(wake_timer_stop_enable),
        .stop_request(stop_request), .wake_event(wake_event),
        .irq_pending(irq_pending), .vector_req(vector_req),
        .bus_addr(bus_addr), .supply_irq(supply_irq),
        .supply_reset(supply_reset), .stop_mode(stop_mode),
        .periph_clk_en(periph_clk_en), .debug_clk_en(debug_clk_en),
        .power(power), .region(region), .vector_valid(vector_valid),
        .vector_addr(vector_addr), .vector_hi_first(vector_hi_first));

    smv_core_model u_core (.mclk(mclk), .stop_request(stop_request),
        .vector_req(vector_req), .vector_valid(vector_valid),
        .vector_addr(vector_addr));

    // ********************************************
    // Clock, hang guard and reporting
    // ********************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[ERR] %0t run hung", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic note(string s);
        err_count++;
        $display("[ERR] %0t %s", $time, s);
    endtask : note

    task automatic cmp_bit(logic g, logic e);
        comparisons++;
        if (g !== e) note($sformatf("bit %b exp %b", g, e));
    endtask : cmp_bit

    task automatic cmp_addr(logic [15:0] g, logic [15:0] e);
        comparisons++;
        if (g !== e) note($sformatf("value %h exp %h", g, e));
    endtask : cmp_addr

    task automatic cmp_mode(smv_mode_type g, smv_mode_type e);
        comparisons++;
        if (g !== e) note($sformatf("mode %h exp %h", g, e));
    endtask : cmp_mode

    task automatic cmp_power(smv_power_type g, smv_power_type e);
        comparisons++;
        if (g !== e) note($sformatf("power %h exp %h", g, e));
    endtask : cmp_power

    // Expected unit states; clock source off in stop2, or in stop3 when the detector stays on and neither clock_gen_stop_enable nor debug is set
    function automatic smv_power_type exp_power(smv_mode_type md, logic dt,
                                                logic dbg);
        smv_power_type p;
        logic s2;
        if (md == SMV_RUN) begin
            return '{SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON,
                SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON, SMV_PWR_ON,
                SMV_PWR_ON, 1'b0};
        end
        s2 = (md == SMV_STOP2);
        p.pins_held = 1'b1;
        p.ram = SMV_PWR_STANDBY;
        p.core = s2 ? SMV_PWR_OFF : SMV_PWR_STANDBY;
        p.flash = p.core;
        p.ports = p.core;
        p.timers = p.core;
        p.regulator = (!s2 && (dt || dbg)) ? SMV_PWR_ON : SMV_PWR_STANDBY;
        p.converter = s2 ? SMV_PWR_OFF : (converter_async_clock && dt)
            ? SMV_PWR_ON : SMV_PWR_STANDBY;
        p.clock_gen = s2 ? SMV_PWR_OFF : (clock_gen_stop_enable || dbg)
            ? SMV_PWR_ON : dt ? SMV_PWR_OFF : SMV_PWR_STANDBY;
        p.wake_timer = wake_timer_stop_enable ? SMV_PWR_ON
            : s2 ? SMV_PWR_OFF : SMV_PWR_STANDBY;
        return p;
    endfunction : exp_power

    function automatic smv_region_type exp_region(logic [15:0] a);
        return '{a <= 16'h005f, a >= 16'h1800 && a <= 16'h184f,
                 a >= 16'hffb0 && a <= 16'hffbf};
    endfunction : exp_region

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        {reset, supply_low, supply_detector_enable, wake_event} = 4'hf;
        {supply_detector_stop_enable, supply_detector_reset_select} = 2'h0;
        {partial_powerdown_select, debug_mode_enable} = 2'h0;
        {clock_gen_stop_enable, converter_async_clock} = 2'h0;
        wake_timer_stop_enable = 1'b0;
        irq_pending = 12'h000;
        bus_addr = 16'h0000;
        void'($urandom(32'hd6c5));
        repeat (12) @(posedge mclk);
        #1 reset = 1'b0;
        {supply_low, supply_detector_enable, wake_event} = 3'h0;
        cmp_mode(stop_mode, SMV_RUN);
        cmp_bit(vector_valid, 1'b0);
        cmp_bit(periph_clk_en, 1'b1);
        cmp_power(power, exp_power(SMV_RUN, 1'b0, 1'b0));
        // Register regions: every boundary, then random addresses
        for (i = 0; i < 51; i++) begin
            @(posedge mclk);
            #1 bus_addr = (i < 11) ? edges[i] : 16'($urandom);
            #1 cmp_addr(16'(region), 16'(exp_region(bus_addr)));
        end
        // Each source alone, then mixtures where the lowest index wins
        for (i = 0; i < 32; i++) begin
            irq_pending = (i < 12) ? 12'h001 << i : 12'($urandom) | 12'h800;
            for (j = 11; j >= 0; j--) if (irq_pending[j]) k = 4'(j);
            u_core.fetch(got, ha, la);
            cmp_bit(got, 1'b1);
            cmp_addr(ha, vec_tab[k]);
            cmp_addr(la, vec_tab[k] + 16'h0001);
            cmp_bit(ha >= 16'hffc0 && ha <= 16'hffcf, 1'b0);
            cmp_bit(vector_hi_first, 1'b1);
        end
        // No pending source: no fetch, address holds
        prev = vector_addr;
        irq_pending = 12'h000;
        u_core.fetch(got, ha, la);
        cmp_bit(got, 1'b0);
        cmp_addr(ha, prev);
        // Stop entry: all 16 corners of debug, detector enables and powerdown select first, then random settings
        for (i = 0; i < 40; i++) begin
            k = (i < 16) ? 4'(i) : 4'($urandom);
            {debug_mode_enable, supply_detector_stop_enable} = k[3:2];
            {supply_detector_enable, partial_powerdown_select} = k[1:0];
            {clock_gen_stop_enable, converter_async_clock} = 2'($urandom);
            wake_timer_stop_enable = 1'($urandom);
            det = k[1] & k[2];
            m = (k[0] && !det && !k[3]) ? SMV_STOP2 : SMV_STOP3;
            u_core.exec_stop();
            cmp_mode(stop_mode, m);
            cmp_bit(periph_clk_en, 1'b0);
            cmp_bit(debug_clk_en, k[3]);
            pe = exp_power(m, det, k[3]);
            cmp_power(power, pe);
            u_core.exec_stop();
            cmp_mode(stop_mode, m);
            @(posedge mclk);
            #1 wake_event = 1'b1;
            @(posedge mclk);
            #1 wake_event = 1'b0;
            cmp_mode(stop_mode, SMV_RUN);
            cmp_bit(periph_clk_en, 1'b1);
            cmp_power(power, exp_power(SMV_RUN, 1'b0, 1'b0));
        end
        // Reset taken while stopped must bring back the run state
        u_core.exec_stop();
        @(posedge mclk);
        #1 reset = 1'b1;
        @(posedge mclk);
        #1 reset = 1'b0;
        cmp_mode(stop_mode, SMV_RUN);
        cmp_power(power, exp_power(SMV_RUN, 1'b0, 1'b0));
        cmp_bit(vector_valid, 1'b0);
        cmp_addr(vector_addr, 16'h0000);
        // Detector response kinds, in run with stop enable clear
        supply_detector_stop_enable = 1'b0;
        for (i = 0; i < 4; i++) begin
            {supply_detector_reset_select, supply_detector_enable} = 2'(i);
            supply_low = 1'b1;
            repeat (4) @(posedge mclk);
            #1 cmp_bit(supply_irq, i == 1);
            cmp_bit(supply_reset, i == 3);
            supply_low = 1'b0;
            repeat (4) @(posedge mclk);
            #1 cmp_bit(supply_irq | supply_reset, 1'b0);
        end
        stop_test();
    end
endmodule : tb_stop_mode_and_vector_map
`default_nettype wire
